/* File: fpcl_asserts.sv */
module fpcl_asserts #(
   parameter int unsigned CF2CK_CYCLES = 300
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire fpcl_pkg::fpcl_sense_type link_in,
   input wire fpcl_pkg::fpcl_drive_type link_out
);
   localparam int REQ_MIN = 250;
   typedef struct packed {
      logic [19:0] low;
      logic [19:0] since;
      logic [19:0] st_hi;
      logic saw_st;
      logic armed;
      logic clk;
      logic [1:0] falls;
   } fpcl_chk_type;
   fpcl_chk_type h_q;
   fpcl_chk_type h_d;
   // the 20-bit counters run free: a run stays far below their wrap point
   always_comb begin
      h_d = h_q;
      h_d.clk = link_out.clock;
      h_d.low = link_out.request_n ? '0 : h_q.low + 20'h0_0001;
      h_d.since = link_out.request_n ? h_q.since + 20'h0_0001 : '0;
      h_d.st_hi = (link_out.request_n && link_in.status_n) ? h_q.st_hi + 20'h0_0001 : '0;
      h_d.saw_st = !link_out.request_n && (h_q.saw_st || !link_in.status_n);
      h_d.armed = !link_out.request_n || (h_q.armed && !link_out.clock);
      if (!link_in.load_done) begin
         h_d.falls = 2'h0;
      end else if (h_q.clk && !link_out.clock && h_q.falls != 2'h2) begin
         h_d.falls = h_q.falls + 2'h1;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         h_q <= '0;
      end else begin
         h_q <= h_d;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence clk_low_s;
      !link_out.clock [*4];
   endsequence
   req_width_a: assert property ($rose(link_out.request_n) |-> h_q.low >= REQ_MIN)
      else $error("config request low too short");
   req_wait_a: assert property ($rose(link_out.request_n) |-> h_q.saw_st)
      else $error("config request released before status low");
   clk_high_a: assert property ($rose(link_out.clock) |-> ##4 !link_out.clock)
      else $error("config clock high phase wrong");
   clk_low_a: assert property ($fell(link_out.clock) |-> clk_low_s)
      else $error("config clock low phase too short");
   data_setup_a: assert property ($changed(link_out.data) |-> clk_low_s)
      else $error("data changed too close to a rising edge");
   first_edge_a: assert property ($rose(link_out.clock) && h_q.armed |->
      h_q.since >= CF2CK_CYCLES || h_q.st_hi >= REQ_MIN)
      else $error("first rising edge too early");
   init_edges_a: assert property ($fell(link_out.data_oe) && link_in.load_done |->
      h_d.falls == 2'h2)
      else $error("data released before two falling edges");
   clk_parked_a: assert property (link_in.load_done && !link_out.data_oe |-> !link_out.clock)
      else $error("config clock not parked low");
endmodule

/* File: fpcl_dev_model.sv */
module fpcl_dev_model (
   input wire logic hclk,
   input wire fpcl_pkg::fpcl_drive_type pins,
   input wire logic [3:0] ratio,
   input wire logic init_pin,
   input wire logic fault,
   output fpcl_pkg::fpcl_sense_type sense
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int N_WORDS = 3;
   logic [31:0] got[$];
   int edge_n = 0;
   int falls = 0;
   initial begin
      sense = '0;
      repeat (30) @(posedge hclk);
      sense.status_n <= 1'b1;
   end
   // delays are scaled down, so the low pulse is far shorter than on silicon
   always begin
      @(negedge pins.request_n);
      repeat (10) @(posedge hclk);
      sense <= '0;
      got.delete();
      edge_n = 0;
      falls = 0;
      @(posedge pins.request_n);
      repeat (40) @(posedge hclk);
      sense.status_n <= 1'b1;
   end
   always @(posedge fault) sense.status_n <= 1'b0;
   always @(negedge fault) sense.status_n <= 1'b1;
   always @(posedge pins.clock) begin
      if (sense.status_n && !sense.load_done && edge_n < N_WORDS * ratio) begin
         if (edge_n % ratio == 0) got.push_back(pins.data);
         edge_n++;
         if (edge_n == N_WORDS * ratio) sense.load_done <= 1'b1;
      end
   end
   always @(negedge pins.clock) if (sense.load_done && falls < 2) falls++;
   always begin
      wait (falls == 2);
      repeat (50) @(posedge hclk);
      if (init_pin) sense.init_done <= 1'b1;
      wait (falls != 2);
   end
endmodule

/* File: fpcl_host.sv */
module fpcl_host #(
   parameter int unsigned CF2CK_CYCLES = fpcl_pkg::CF2CK_CYC,
   parameter int unsigned USER_MODE_CYCLES = fpcl_pkg::USER_MODE_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire fpcl_pkg::fpcl_sense_type link_in,
   output fpcl_pkg::fpcl_drive_type link_out
);
   localparam logic [fpcl_pkg::TMR_W-1:0] REQ_T = fpcl_pkg::TMR_W'(fpcl_pkg::REQ_LOW_CYC);
   localparam logic [fpcl_pkg::TMR_W-1:0] ST2CK_T = fpcl_pkg::TMR_W'(fpcl_pkg::ST2CK_CYC);
   localparam logic [fpcl_pkg::TMR_W-1:0] CF2CK_T = fpcl_pkg::TMR_W'(CF2CK_CYCLES);
   localparam logic [fpcl_pkg::TMR_W-1:0] UM_T = fpcl_pkg::TMR_W'(USER_MODE_CYCLES);

   // q is the whole state of the block, s its next value
   fpcl_pkg::fpcl_regs_type q;
   fpcl_pkg::fpcl_regs_type s;

   // read data is built from the next state, so a write in the same edge already shows
   function automatic logic [31:0] read_word(input logic [7:0] a,
                                             input fpcl_pkg::fpcl_regs_type r);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (a == fpcl_pkg::OFS_CTRL) begin
         v[fpcl_pkg::CTRL_WIDTH +: 2] = r.cfg.width;
         v[fpcl_pkg::CTRL_DECOMP] = r.cfg.decomp;
         v[fpcl_pkg::CTRL_SECURE] = r.cfg.secure;
         v[fpcl_pkg::CTRL_MONITOR] = r.cfg.monitor;
         v[fpcl_pkg::CTRL_INIT_EN] = r.cfg.init_en;
      end else if (a == fpcl_pkg::OFS_STATUS) begin
         v[fpcl_pkg::ST_STATE +: 4] = r.state;
         v[fpcl_pkg::ST_STATUS] = r.sync2.status_n;
         v[fpcl_pkg::ST_LOADED] = r.sync2.load_done;
         v[fpcl_pkg::ST_INIT] = r.sync2.init_done;
         v[fpcl_pkg::ST_BUSY] = r.word_valid | (r.cyc_left != 4'h0);
         v[fpcl_pkg::ST_ERROR] = r.err;
         v[fpcl_pkg::ST_DONE] = r.done;
      end
      return v;
   endfunction

   always_comb begin
      logic tick;
      logic start_p;
      logic abort_p;
      logic finish_p;
      logic done_ph;
      logic acc;
      s = q;
      // fixed 64 ns clock period keeps under the lower limit of the widest mode
      tick = (q.div == fpcl_pkg::HALF_LAST);
      start_p = 1'b0;
      abort_p = 1'b0;
      finish_p = 1'b0;
      // only the second stage is ever looked at
      s.sync1 = link_in;
      s.sync2 = q.sync1;
      s.div = tick ? 3'h0 : q.div + 3'h1;
      if (q.tmr != '0) begin
         s.tmr = q.tmr - 1'b1;
      end

      // bus data phase
      done_ph = q.ph_valid & q.hreadyout;
      if (done_ph) begin
         s.ph_valid = 1'b0;
         if (q.ph_write && q.ph_addr == fpcl_pkg::OFS_CTRL) begin
            start_p = hwdata[fpcl_pkg::CTRL_START];
            abort_p = hwdata[fpcl_pkg::CTRL_ABORT];
            finish_p = hwdata[fpcl_pkg::CTRL_FINISH];
            s.cfg.width = fpcl_pkg::fpcl_width_type'(hwdata[fpcl_pkg::CTRL_WIDTH +: 2]);
            s.cfg.decomp = hwdata[fpcl_pkg::CTRL_DECOMP];
            s.cfg.secure = hwdata[fpcl_pkg::CTRL_SECURE];
            s.cfg.monitor = hwdata[fpcl_pkg::CTRL_MONITOR];
            s.cfg.init_en = hwdata[fpcl_pkg::CTRL_INIT_EN];
         end else if (q.ph_write && q.ph_addr == fpcl_pkg::OFS_DATA) begin
            s.word = hwdata;
            s.word_valid = 1'b1;
         end
      end else if (q.ph_valid && !q.word_valid) begin
         // stalled data word: the holding slot has been taken by the link
         s.hreadyout = 1'b1;
      end

      unique case (q.state)
         fpcl_pkg::ST_IDLE: begin
            s.pins.request_n = 1'b1;
         end

         // request stays low until both its minimum width and status low are seen
         fpcl_pkg::ST_REQ: begin
            if (q.tmr == '0 && !q.sync2.status_n) begin
               s.pins.request_n = 1'b1;
               s.tmr = CF2CK_T;
               s.state = fpcl_pkg::ST_WSTAT;
            end
         end

         // watching status gives the earlier start; otherwise the worst-case wait
         fpcl_pkg::ST_WSTAT: begin
            if (q.cfg.monitor && q.sync2.status_n) begin
               s.tmr = ST2CK_T;
               s.state = fpcl_pkg::ST_SETTLE;
            end else if (!q.cfg.monitor && q.tmr == '0) begin
               s.pins.data_oe = 1'b1;
               s.state = fpcl_pkg::ST_LOAD;
            end
         end

         // status must stay high through the settle time
         fpcl_pkg::ST_SETTLE: begin
            if (!q.sync2.status_n) begin
               s.state = fpcl_pkg::ST_ERR;
            end else if (q.tmr == '0) begin
               s.pins.data_oe = 1'b1;
               s.state = fpcl_pkg::ST_LOAD;
            end
         end

         // one word per r clock periods; the clock pauses low while the slot is empty
         fpcl_pkg::ST_LOAD: begin
            if (finish_p) begin
               s.finish_req = 1'b1;
            end
            if (tick) begin
               if (q.pins.clock) begin
                  s.pins.clock = 1'b0;
               end else if (q.cyc_left != 4'h0) begin
                  // extra cycles of the period give the device time to decode
                  s.pins.clock = 1'b1;
                  s.cyc_left = q.cyc_left - 4'h1;
               end else if (q.word_valid) begin
                  // word put on while the clock is low, one half period ahead
                  s.pins.data = fpcl_pkg::lane_mask(q.cfg.width, q.word);
                  s.cyc_left = fpcl_pkg::clk_ratio(q.cfg.width, q.cfg.decomp,
                                                   q.cfg.secure);
                  s.word_valid = 1'b0;
               end
            end
            if (!q.sync2.status_n) begin
               s.state = fpcl_pkg::ST_ERR;
            end else if (q.finish_req && !q.word_valid && q.cyc_left == 4'h0 &&
                         !q.pins.clock) begin
               s.state = fpcl_pkg::ST_FLUSH;
            end
         end

         // clock stays low until the device reports the load complete
         fpcl_pkg::ST_FLUSH: begin
            if (!q.sync2.status_n) begin
               s.state = fpcl_pkg::ST_ERR;
            end else if (q.sync2.load_done) begin
               s.edges = 2'h2;
               s.state = fpcl_pkg::ST_EDGES;
            end
         end

         // two extra falling edges start the device's initialization
         fpcl_pkg::ST_EDGES: begin
            if (tick) begin
               if (q.pins.clock) begin
                  s.pins.clock = 1'b0;
                  s.edges = q.edges - 2'h1;
               end else if (q.edges != 2'h0) begin
                  s.pins.clock = 1'b1;
               end
            end
            if (q.edges == 2'h0 && !q.pins.clock) begin
               // data lines go back to the device as user pins
               s.pins.data_oe = 1'b0;
               s.tmr = UM_T;
               s.state = fpcl_pkg::ST_INITW;
            end
         end

         // without the init pin the worst-case user-mode time is waited out
         fpcl_pkg::ST_INITW: begin
            if (q.cfg.init_en && q.sync2.init_done) begin
               s.done = 1'b1;
               s.state = fpcl_pkg::ST_DONE_S;
            end else if (q.tmr == '0) begin
               s.done = !q.cfg.init_en;
               s.state = q.cfg.init_en ? fpcl_pkg::ST_ERR : fpcl_pkg::ST_DONE_S;
            end
         end

         // clock parked low: the device ignores it, but it must not float
         fpcl_pkg::ST_DONE_S: begin
            s.pins.clock = 1'b0;
         end

         // a high phase is finished at its tick, so the device never sees a runt pulse
         fpcl_pkg::ST_ERR: begin
            if (tick) begin
               s.pins.clock = 1'b0;
            end
            s.pins.data_oe = 1'b0;
         end

         // unused codes fall back to idle
         default: begin
            s.state = fpcl_pkg::ST_IDLE;
         end
      endcase

      // a new request restarts from any state, as from user mode
      if (start_p || abort_p) begin
         s.pins.clock = 1'b0;
         s.pins.data_oe = 1'b0;
         s.cyc_left = 4'h0;
         s.finish_req = 1'b0;
         s.word_valid = 1'b0;
         s.done = 1'b0;
         s.err = 1'b0;
         s.pins.request_n = 1'b1;
         s.state = fpcl_pkg::ST_IDLE;
      end
      if (start_p && !abort_p) begin
         s.pins.request_n = 1'b0;
         s.tmr = REQ_T;
         s.state = fpcl_pkg::ST_REQ;
      end
      // the error flag is set after any clear, on entry to the error state; a start or abort in the same cycle overrides that entry, so the fault is dropped
      if (s.state == fpcl_pkg::ST_ERR && q.state != fpcl_pkg::ST_ERR) begin
         s.err = 1'b1;
      end

      // bus address phase, decided on the settled next state
      acc = hsel & htrans[1] & hready;
      if (acc) begin
         s.ph_valid = 1'b1;
         s.ph_write = hwrite;
         s.ph_addr = haddr[7:0];
         s.hrdata = hwrite ? 32'h0000_0000 : read_word(haddr[7:0], s);
         // only a data write that finds the holding slot full waits
         s.hreadyout = !(hwrite && haddr[7:0] == fpcl_pkg::OFS_DATA && s.word_valid);
      end
      // every transfer ends with an okay response
      s.hresp = 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '{state: fpcl_pkg::ST_IDLE,
                sync1: '{status_n: 1'b1, load_done: 1'b0, init_done: 1'b0},
                sync2: '{status_n: 1'b1, load_done: 1'b0, init_done: 1'b0},
                pins: '{request_n: 1'b1, clock: 1'b0, data: 32'h0000_0000, data_oe: 1'b0},
                cfg: fpcl_pkg::fpcl_cfg_type'(fpcl_pkg::CTRL_RESET[5:0]),
                div: 3'h0,
                tmr: '0,
                cyc_left: 4'h0,
                edges: 2'h0,
                word: 32'h0000_0000,
                word_valid: 1'b0,
                finish_req: 1'b0,
                err: 1'b0,
                done: 1'b0,
                ph_valid: 1'b0,
                ph_write: 1'b0,
                ph_addr: 8'h00,
                hreadyout: 1'b1,
                hresp: 1'b0,
                hrdata: 32'h0000_0000};
      end else begin
         q <= s;
      end
   end

   assign hreadyout = q.hreadyout;
   assign hresp = q.hresp;
   assign hrdata = q.hrdata;
   assign link_out = q.pins;
endmodule

/* File: fpcl_pkg.sv */
package fpcl_pkg;
   localparam int unsigned CLK_MHZ = 125;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   // control word fields
   localparam int unsigned CTRL_START = 0;
   localparam int unsigned CTRL_ABORT = 1;
   localparam int unsigned CTRL_FINISH = 2;
   localparam int unsigned CTRL_WIDTH = 3;
   localparam int unsigned CTRL_DECOMP = 5;
   localparam int unsigned CTRL_SECURE = 6;
   localparam int unsigned CTRL_MONITOR = 7;
   localparam int unsigned CTRL_INIT_EN = 8;
   // status word fields
   localparam int unsigned ST_STATE = 0;
   localparam int unsigned ST_STATUS = 4;
   localparam int unsigned ST_LOADED = 5;
   localparam int unsigned ST_INIT = 6;
   localparam int unsigned ST_BUSY = 7;
   localparam int unsigned ST_ERROR = 8;
   localparam int unsigned ST_DONE = 9;
   // link timing in its own units, then in hclk cycles
   localparam int unsigned REQ_LOW_NS = 2000;
   localparam int unsigned ST2CK_NS = 2000;
   localparam int unsigned CF2CK_US = 1506;
   localparam int unsigned USER_MODE_US = 437;
   localparam int unsigned REQ_LOW_CYC = (REQ_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned ST2CK_CYC = (ST2CK_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CF2CK_CYC = CF2CK_US * CLK_MHZ;
   localparam int unsigned USER_MODE_CYC = USER_MODE_US * CLK_MHZ;
   // last divider count of the config clock half period (4 hclk cycles): 64 ns period, well under both limits
   localparam logic [2:0] HALF_LAST = 3'h3;
   localparam int unsigned TMR_W = 18;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   typedef enum logic [1:0] {
      WIDTH_8 = 2'h0,
      WIDTH_16 = 2'h1,
      WIDTH_32 = 2'h2
   } fpcl_width_type;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_REQ = 4'h1,
      ST_WSTAT = 4'h3,
      ST_SETTLE = 4'h2,
      ST_LOAD = 4'h6,
      ST_FLUSH = 4'h7,
      ST_EDGES = 4'h5,
      ST_INITW = 4'h4,
      ST_DONE_S = 4'hc,
      ST_ERR = 4'hd
   } fpcl_state_type;

   typedef struct packed {
      logic status_n;
      logic load_done;
      logic init_done;
   } fpcl_sense_type;

   typedef struct packed {
      logic request_n;
      logic clock;
      logic [31:0] data;
      logic data_oe;
   } fpcl_drive_type;

   typedef struct packed {
      fpcl_width_type width;
      logic decomp;
      logic secure;
      logic monitor;
      logic init_en;
   } fpcl_cfg_type;

   typedef struct packed {
      fpcl_state_type state;
      fpcl_sense_type sync1;
      fpcl_sense_type sync2;
      fpcl_drive_type pins;
      fpcl_cfg_type cfg;
      logic [2:0] div;
      logic [TMR_W-1:0] tmr;
      logic [3:0] cyc_left;
      logic [1:0] edges;
      logic [31:0] word;
      logic word_valid;
      logic finish_req;
      logic err;
      logic done;
      logic ph_valid;
      logic ph_write;
      logic [7:0] ph_addr;
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } fpcl_regs_type;

   function automatic logic [3:0] clk_ratio(input fpcl_width_type w, input logic dc,
                                            input logic sc);
      logic [3:0] r;
      r = 4'h1;
      unique case (w)
         WIDTH_8: r = dc ? 4'h2 : 4'h1;
         WIDTH_16: r = dc ? 4'h4 : (sc ? 4'h2 : 4'h1);
         default: r = dc ? 4'h8 : (sc ? 4'h4 : 4'h1);
      endcase
      return r;
   endfunction

   function automatic logic [31:0] lane_mask(input fpcl_width_type w, input logic [31:0] d);
      logic [31:0] m;
      m = d;
      unique case (w)
         WIDTH_8: m = {24'h00_0000, d[7:0]};
         WIDTH_16: m = {16'h0000, d[15:0]};
         default: m = d;
      endcase
      return m;
   endfunction
endpackage

/* File: tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [1:0] w;
      logic dec;
      logic sec;
      logic [3:0] r;
   } fpcl_row_type;
   localparam fpcl_row_type ROWS [12] = '{
      '{2'h0, 1'b0, 1'b0, 4'h1}, '{2'h0, 1'b0, 1'b1, 4'h1}, '{2'h0, 1'b1, 1'b0, 4'h2},
      '{2'h0, 1'b1, 1'b1, 4'h2}, '{2'h1, 1'b0, 1'b0, 4'h1}, '{2'h1, 1'b0, 1'b1, 4'h2},
      '{2'h1, 1'b1, 1'b0, 4'h4}, '{2'h1, 1'b1, 1'b1, 4'h4}, '{2'h2, 1'b0, 1'b0, 4'h1},
      '{2'h2, 1'b0, 1'b1, 4'h4}, '{2'h2, 1'b1, 1'b0, 4'h8}, '{2'h2, 1'b1, 1'b1, 4'h8}};
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [3:0] ratio = 4'h1;
   logic init_pin = 1'b0;
   logic fault = 1'b0;
   fpcl_pkg::fpcl_sense_type sense;
   fpcl_pkg::fpcl_drive_type pins;
   int n_fail = 0;
   int checks_done = 0;
   always #4 hclk = ~hclk;
   fpcl_host #(.CF2CK_CYCLES(300), .USER_MODE_CYCLES(200)) fpcl_host_inst (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(3'h2),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .link_in(sense),
      .link_out(pins)
   );
   fpcl_dev_model fpcl_dev_model_inst (
      .hclk(hclk),
      .pins(pins),
      .ratio(ratio),
      .init_pin(init_pin),
      .fault(fault),
      .sense(sense)
   );
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // a held data word can stall the bus for a whole word period or more
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20000);
      if (n >= 20000) chk(32'h0, 32'h1);
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h00_0000, a};
      wait_rdy();
      @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0);
      @(posedge hclk);
   endtask
   function automatic logic [31:0] word(input int i, input int k);
      return 32'h9e37_79b9 * (i * 3 + k + 1);
   endfunction
   initial begin
      logic [31:0] st;
      logic [31:0] ctl;
      logic [31:0] m;
      int n;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk({30'h0, pins.request_n, pins.data_oe}, 32'h2);
      bus(1'b0, fpcl_pkg::OFS_CTRL, '0, st);
      chk(st, fpcl_pkg::CTRL_RESET);
      bus(1'b1, fpcl_pkg::OFS_STATUS, 32'hffff_ffff, st);
      bus(1'b0, 8'h3c, '0, st);
      chk(st, 32'h0);
      bus(1'b0, fpcl_pkg::OFS_STATUS, '0, st);
      chk(st & 32'h10f, {28'h0, fpcl_pkg::ST_IDLE});
      for (int i = 0; i < 12; i++) begin
         ratio <= ROWS[i].r;
         init_pin <= i[1];
         ctl = '0;
         ctl[fpcl_pkg::CTRL_WIDTH +: 2] = ROWS[i].w;
         ctl[fpcl_pkg::CTRL_DECOMP] = ROWS[i].dec;
         ctl[fpcl_pkg::CTRL_SECURE] = ROWS[i].sec;
         ctl[fpcl_pkg::CTRL_MONITOR] = i[0];
         ctl[fpcl_pkg::CTRL_INIT_EN] = i[1];
         bus(1'b1, fpcl_pkg::OFS_CTRL, ctl | 32'h1, st);
         bus(1'b0, fpcl_pkg::OFS_CTRL, '0, st);
         chk(st, ctl);
         for (int k = 0; k < 3; k++) bus(1'b1, fpcl_pkg::OFS_DATA, word(i, k), st);
         bus(1'b1, fpcl_pkg::OFS_CTRL, ctl | 32'h4, st);
         n = 0;
         do begin
            bus(1'b0, fpcl_pkg::OFS_STATUS, '0, st);
            n++;
         end while (st[fpcl_pkg::ST_DONE] !== 1'b1 && n < 900);
         chk(st & 32'h13f, {26'h0, 2'h3, fpcl_pkg::ST_DONE_S});
         chk({30'h0, pins.data_oe, pins.clock}, 32'h0);
         chk(32'(fpcl_dev_model_inst.got.size()), 32'h3);
         for (int k = 0; k < 3; k++) begin
            m = word(i, k);
            if (ROWS[i].w == 2'h0) m[31:8] = '0;
            if (ROWS[i].w == 2'h1) m[31:16] = '0;
            chk(fpcl_dev_model_inst.got[k], m);
         end
      end
      // status pulled low in mid-load must end the load at once
      ratio <= 4'h8;
      bus(1'b1, fpcl_pkg::OFS_CTRL, 32'h31, st);
      bus(1'b1, fpcl_pkg::OFS_DATA, 32'h1234_5678, st);
      n = 0;
      while (pins.data_oe !== 1'b1 && n < 2000) begin
         @(posedge hclk);
         n++;
      end
      repeat (20) @(posedge hclk);
      fault <= 1'b1;
      repeat (10) @(posedge hclk);
      bus(1'b0, fpcl_pkg::OFS_STATUS, '0, st);
      chk(st & 32'h10f, 32'h100 | {28'h0, fpcl_pkg::ST_ERR});
      chk({30'h0, pins.data_oe, pins.clock}, 32'h0);
      fault <= 1'b0;
      bus(1'b1, fpcl_pkg::OFS_CTRL, 32'h2, st);
      bus(1'b0, fpcl_pkg::OFS_STATUS, '0, st);
      chk(st & 32'h100, 32'h0);
      give_verdict();
   end
   initial begin
      repeat (90000) @(posedge hclk);
      n_fail++;
      give_verdict();
   end
endmodule
bind fpcl_host fpcl_asserts #(.CF2CK_CYCLES(CF2CK_CYCLES)) fpcl_asserts_inst (
   .hclk(hclk),
   .hresetn(hresetn),
   .link_in(link_in),
   .link_out(link_out)
);
